//--- hdl/sacp_map.vh
/*
  Constants for the serial converter control port: control-byte field
  positions, reset values and internal-clock conversion timing.
  Assumes inclusion by sacp_top.v only.
*/
`ifndef SACP_MAP_VH
`define SACP_MAP_VH

// ----------------------------------------
// Control-byte fields
// ----------------------------------------
`define SACP_BIT_START 7
`define SACP_BIT_SEL_HI 6
`define SACP_BIT_SEL_MID 5
`define SACP_BIT_SEL_LO 4
`define SACP_BIT_POLARITY 3
`define SACP_BIT_INCFG 2
`define SACP_BIT_POWER 1
`define SACP_BIT_CLKSRC 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SACP_CLK_MHZ 40
`define SACP_INT_CONV_NS 25000
`define SACP_INT_CONV_CYC 11'h3e8
`define SACP_STRB_PERIODS 2'h2
`define SACP_LAST_CTRL_BIT 3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SACP_RST_EXT 1'b0
`define SACP_RST_STRB 1'b1

`endif

//--- hdl/sacp_top.v
/*
  Serial control-byte front end of an 8-bit multichannel converter.
  Assumes CS_N, SCLK and DIN come from a host in another clock domain
  and are sampled here by REF_CLK; SAR_DATA and SAR_BELOW_ZERO come from
  the analog core on REF_CLK. Pin output enables are active low.
*/
// What this block and its host do
// RULE1: After chip select falls, first sampled one is the start bit.
// RULE2: Zeros before the start bit are ignored without any effect.
// RULE3: Sample DIN on each SCLK rise only while chip select is low.
// RULE4: Byte order: start, select hi/mid/lo, polarity, config, power, clock.
// RULE5: Bit 3 set means unipolar straight coding, clear means bipolar.
// RULE6: Host pairs bipolar conversion with differential inputs.
// RULE7: Bit 2 set means single-ended to common pin, clear differential.
// RULE8: Bit 1 set keeps device powered, clear selects power-down.
// RULE9: Bit 0 set selects external serial clock, clear internal clock.
// RULE10: Eight-channel differential: low bits pick pair, top bit picks polarity.
// RULE11: Four-channel single-ended: ignore low bit, index is mid then top.
// RULE12: Four-channel differential: mid picks pair, top set makes odd positive.
// RULE13: External mode: strobe high two SCLK periods before result MSB.
// RULE14: Ten SCLK cycles per external conversion with continuous bytes.
// RULE15: Strobe and data output change only on SCLK falling edges; STRB also drops on external-mode chip-select fall and rises at internal timer end.
// RULE16: Host idles clock low and samples on the leading edge.
// RULE17: Byte host uses three transfers: control byte then two result bytes.
// RULE18: All-ones byte: single-ended unipolar top channel, external, powered.
// RULE19: Unipolar differential with negative input gives code zero.
// RULE20: Host sends a fresh control byte before each conversion.
// RULE21: Eight-channel single-ended index is mid, lo, top; negative is common.
// RULE22: Conversion begins on the SCLK fall after the eighth control bit.
// RULE23: External mode: eight result bits MSB first, then zeros.
// RULE24: External mode: float outputs while deselected, strobe low after select.
// RULE25: Decoded fields are held from the eighth bit for the conversion.
`timescale 1ns/1ps
`include "sacp_map.vh"
`default_nettype none

module sacp_top #(
  parameter EIGHT_CHAN = 1
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire CS_N,
  input wire SCLK,
  input wire DIN,
  input wire [7:0] SAR_DATA,
  input wire SAR_BELOW_ZERO,
  output reg DOUT,
  output reg DOUT_OE_N,
  output reg STRB,
  output reg STRB_OE_N,
  output reg CONV_START,
  output reg [2:0] CHAN_POS,
  output reg [2:0] CHAN_NEG,
  output reg NEG_COMMON,
  output reg UNIPOLAR,
  output reg SINGLE_ENDED,
  output reg EXT_CLOCK,
  output reg POWER_DOWN
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  // Typical internal conversion time in REF_CLK cycles
  localparam [10:0] INT_CYC_W = `SACP_INT_CONV_CYC;
  localparam [1:0] ST_HUNT = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg cs_m_q, cs_s_q, cs_p_q;
  reg sclk_m_q, sclk_s_q, sclk_p_q;
  reg din_m_q, din_s_q;

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_p_q <= 1'b1;
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end
    else
    begin
      cs_m_q <= CS_N;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      sclk_m_q <= SCLK;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      din_m_q <= DIN;
      din_s_q <= din_m_q;
    end
  end

  wire sel = ~cs_s_q;
  wire rise = sel & sclk_s_q & ~sclk_p_q; // [RULE3]
  wire fall = sel & ~sclk_s_q & sclk_p_q; // [RULE15]
  wire cs_fall = ~cs_s_q & cs_p_q;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] st_q;
  reg [2:0] cnt_q;
  reg [5:0] shreg_q;
  reg pend_q;
  reg [1:0] sc_q;
  reg [7:0] out_q;
  reg [7:0] res_q;
  reg int_busy_q;
  reg [10:0] int_cnt_q;
  reg skip_q;
  reg pwr_q;

  // ----------------------------------------
  // Channel decode
  // ----------------------------------------
  reg [2:0] pos_d, neg_d;
  wire [7:0] byte_d = {1'b1, shreg_q, din_s_q}; // [RULE4]
  wire hi = byte_d[`SACP_BIT_SEL_HI];
  wire mid = byte_d[`SACP_BIT_SEL_MID];
  wire lo = byte_d[`SACP_BIT_SEL_LO];
  wire sgl_d = byte_d[`SACP_BIT_INCFG]; // [RULE7]

  always @*
  begin
    if (EIGHT_CHAN != 0)
    begin
      pos_d = {mid, lo, hi}; // [RULE21] [RULE10]
      neg_d = {mid, lo, ~hi}; // [RULE10]
    end
    else
    begin
      pos_d = {1'b0, mid, hi}; // [RULE11] [RULE12]
      neg_d = {1'b0, mid, ~hi}; // [RULE12]
    end
  end

  // ----------------------------------------
  // Framing and conversion
  // ----------------------------------------

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q <= ST_HUNT;
      cnt_q <= 3'h0;
      shreg_q <= 6'h00;
      pend_q <= 1'b0;
      sc_q <= 2'h0;
      out_q <= 8'h00;
      res_q <= 8'h00;
      int_busy_q <= 1'b0;
      int_cnt_q <= 11'h000;
      skip_q <= 1'b0;
      pwr_q <= 1'b1;
      DOUT <= 1'b0;
      DOUT_OE_N <= 1'b1;
      STRB <= `SACP_RST_STRB;
      STRB_OE_N <= 1'b0;
      CONV_START <= 1'b0;
      CHAN_POS <= 3'h0;
      CHAN_NEG <= 3'h0;
      NEG_COMMON <= 1'b0;
      UNIPOLAR <= 1'b0;
      SINGLE_ENDED <= 1'b0;
      EXT_CLOCK <= `SACP_RST_EXT;
      POWER_DOWN <= 1'b0;
    end
    else
    begin
      CONV_START <= 1'b0;
      DOUT_OE_N <= cs_s_q;
      if (EXT_CLOCK)
        STRB_OE_N <= cs_s_q; // [RULE24]
      else
        STRB_OE_N <= 1'b0;
      if (cs_s_q)
      begin
        // Deselect aborts framing and any external conversion
        st_q <= ST_HUNT; // [RULE24]
        pend_q <= 1'b0;
        sc_q <= 2'h0;
        // Internal conversion result survives deselect
        if (EXT_CLOCK)
          out_q <= 8'h00;
      end
      else if (rise)
      begin
        case (st_q)
          ST_HUNT:
          begin
            if (din_s_q) // [RULE1] [RULE2]
            begin
              st_q <= ST_SHIFT;
              cnt_q <= 3'h1;
              POWER_DOWN <= 1'b0;
            end
          end
          ST_SHIFT:
          begin
            shreg_q <= {shreg_q[4:0], din_s_q};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `SACP_LAST_CTRL_BIT)
            begin
              // Hold decoded settings for this conversion
              st_q <= ST_WAIT; // [RULE25]
              pend_q <= 1'b1;
              CHAN_POS <= pos_d;
              CHAN_NEG <= neg_d;
              NEG_COMMON <= sgl_d; // [RULE21]
              SINGLE_ENDED <= sgl_d; // [RULE7] [RULE18]
              UNIPOLAR <= byte_d[`SACP_BIT_POLARITY]; // [RULE5]
              pwr_q <= byte_d[`SACP_BIT_POWER]; // [RULE8]
              EXT_CLOCK <= byte_d[`SACP_BIT_CLKSRC]; // [RULE9]
            end
          end
          default:
            st_q <= st_q;
        endcase
      end
      if (cs_fall && EXT_CLOCK)
        STRB <= 1'b0; // [RULE24]
      if (fall)
      begin
        if (pend_q)
        begin
          // Start on the fall after the eighth bit
          pend_q <= 1'b0; // [RULE22]
          CONV_START <= 1'b1;
          if (UNIPOLAR && !SINGLE_ENDED && SAR_BELOW_ZERO)
            res_q <= 8'h00; // [RULE19]
          else
            res_q <= SAR_DATA;
          DOUT <= 1'b0;
          out_q <= 8'h00;
          // No stale skip from an earlier internal read
          skip_q <= 1'b0;
          if (EXT_CLOCK)
          begin
            STRB <= 1'b1; // [RULE13]
            sc_q <= `SACP_STRB_PERIODS;
            // Drop a stale internal timer
            int_busy_q <= 1'b0;
          end
          else
          begin
            STRB <= 1'b0;
            int_busy_q <= 1'b1;
            int_cnt_q <= INT_CYC_W;
            st_q <= ST_HUNT;
          end
        end
        else if (sc_q == 2'h1)
        begin
          // MSB out after two strobe periods; re-arm framing
          STRB <= 1'b0; // [RULE13] [RULE14]
          sc_q <= 2'h0;
          DOUT <= res_q[7]; // [RULE23]
          out_q <= {res_q[6:0], 1'b0};
          st_q <= ST_HUNT;
          POWER_DOWN <= ~pwr_q; // [RULE8]
        end
        else if (sc_q != 2'h0)
          sc_q <= sc_q - 2'h1;
        else if (skip_q)
        begin
          skip_q <= 1'b0;
          DOUT <= 1'b0;
        end
        else
        begin
          // Drains the result, then zeros
          DOUT <= out_q[7]; // [RULE23]
          out_q <= {out_q[6:0], 1'b0};
        end
      end
      // Internal timer ends the conversion
      if (int_busy_q)
      begin
        if (int_cnt_q == 11'h001)
        begin
          int_busy_q <= 1'b0;
          STRB <= 1'b1;
          out_q <= res_q;
          skip_q <= 1'b1;
          POWER_DOWN <= ~pwr_q;
        end
        int_cnt_q <= int_cnt_q - 11'h001;
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/sacp_chk_sva.sv
/* Port checker for sacp_top.
   Assumes an SCLK of 8 REF_CLK cycles. */
`timescale 1ns/1ps
`default_nettype none
module sacp_chk (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DOUT,
  input wire logic DOUT_OE_N,
  input wire logic STRB,
  input wire logic STRB_OE_N,
  input wire logic CONV_START,
  input wire logic [2:0] CHAN_POS,
  input wire logic [2:0] CHAN_NEG,
  input wire logic NEG_COMMON,
  input wire logic SINGLE_ENDED,
  input wire logic EXT_CLOCK
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  a_dout_float: assert property (
    CS_N[*5] |-> DOUT_OE_N) else $error("data not floated");
  a_strb_float: assert property (
    CS_N[*5] ##0 EXT_CLOCK |-> STRB_OE_N) else $error("strobe not floated");
  a_start_pulse: assert property (
    CONV_START |=> !CONV_START) else $error("start pulse long");
  a_ext_strb: assert property (
    CONV_START && EXT_CLOCK |-> ##[0:1] STRB) else $error("no strobe");
  a_strb_width: assert property (
    $rose(STRB) && EXT_CLOCK |-> STRB[*8] ##[7:9] !STRB)
    else $error("strobe width");
  a_se_common: assert property (
    NEG_COMMON == SINGLE_ENDED) else $error("common pin");
  a_diff_pair: assert property (
    CONV_START && !SINGLE_ENDED |-> CHAN_NEG == (CHAN_POS ^ 3'h1))
    else $error("pair");
  a_dout_edge: assert property (
    $changed(DOUT) && !$past(DOUT_OE_N) |-> $past(SCLK, 5) && !$past(SCLK, 2))
    else $error("data edge");
endmodule
bind sacp_top sacp_chk i_chk (
  .REF_CLK(REF_CLK),
  .RSTN(RSTN),
  .CS_N(CS_N),
  .SCLK(SCLK),
  .DOUT(DOUT),
  .DOUT_OE_N(DOUT_OE_N),
  .STRB(STRB),
  .STRB_OE_N(STRB_OE_N),
  .CONV_START(CONV_START),
  .CHAN_POS(CHAN_POS),
  .CHAN_NEG(CHAN_NEG),
  .NEG_COMMON(NEG_COMMON),
  .SINGLE_ENDED(SINGLE_ENDED),
  .EXT_CLOCK(EXT_CLOCK)
);
`default_nettype wire

//--- testbench/sacp_host.sv
/* Host model: serial master framing one control byte.
   Assumes a 40 MHz REF_CLK. */
`timescale 1ns/1ps
`default_nettype none
module sacp_host (
  input wire logic ref_clk,
  input wire logic dout,
  input wire logic strb,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  logic late;
  initial
  begin
    late = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Clock idles low, read at the rise
  task automatic sbit(input logic d, output logic s);
    din = d;
    repeat (4) @(negedge ref_clk);
    sclk = 1'b1;
    s = dout;
    repeat (4) @(negedge ref_clk);
    sclk = 1'b0;
  endtask
  task automatic frame(input logic [7:0] c, input int z,
    output logic [15:0] rx);
    logic s;
    int k;
    @(negedge ref_clk);
    cs_n = 1'b0;
    repeat (z) sbit(1'b0, s);
    for (k = 7; k >= 0; k--) sbit(c[k], s);
    // External mode keeps SCLK running straight on
    if (!c[0])
      repeat (8) @(negedge ref_clk);
    for (k = 0; k < 1200 && !c[0] && strb !== 1'b1; k++) @(negedge ref_clk);
    if (k == 1200)
      late = 1'b1;
    for (k = 15; k >= 0; k--) sbit(1'b0, rx[k]);
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
/* Bench for sacp_top: random bytes via the host model.
   Assumes the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sar = 8'h00;
  logic below = 1'b0;
  logic [7:0] b;
  logic [7:0] e;
  logic [15:0] rx;
  logic [31:0] r;
  logic [7:0] x;
  logic q;
  int fails = 0;
  int total_checks = 0;
  int nconv = 0;
  int seed = 94062;
  int i;
  wire cs_n, sclk, din, dout, dout_oe_n, strb, strb_oe_n, conv_start;
  wire neg_common, unipolar, single_ended, ext_clock, power_down;
  wire [2:0] chan_pos, chan_neg;
  wire [2:0] pos4, neg4;
  wire dout_line, strb_line;
  wire [7:0] flds = {4'h0, unipolar, single_ended, ext_clock, power_down};
  sacp_top #(.EIGHT_CHAN(1)) i_dut (.REF_CLK(ref_clk), .RSTN(rstn),
    .CS_N(cs_n), .SCLK(sclk), .DIN(din), .SAR_DATA(sar),
    .SAR_BELOW_ZERO(below), .DOUT(dout), .DOUT_OE_N(dout_oe_n),
    .STRB(strb), .STRB_OE_N(strb_oe_n), .CONV_START(conv_start),
    .CHAN_POS(chan_pos), .CHAN_NEG(chan_neg), .NEG_COMMON(neg_common),
    .UNIPOLAR(unipolar), .SINGLE_ENDED(single_ended),
    .EXT_CLOCK(ext_clock), .POWER_DOWN(power_down));
  sacp_top #(.EIGHT_CHAN(0)) i_dut4 (.REF_CLK(ref_clk), .RSTN(rstn),
    .CS_N(cs_n), .SCLK(sclk), .DIN(din), .SAR_DATA(sar),
    .SAR_BELOW_ZERO(below), .DOUT(), .DOUT_OE_N(), .STRB(), .STRB_OE_N(),
    .CONV_START(), .CHAN_POS(pos4), .CHAN_NEG(neg4), .NEG_COMMON(),
    .UNIPOLAR(), .SINGLE_ENDED(), .EXT_CLOCK(), .POWER_DOWN());
  // Undriven pins read as the inverse of the last value
  assign dout_line = dout_oe_n ? ~dout : dout;
  assign strb_line = strb_oe_n ? ~strb : strb;
  sacp_host i_host (.ref_clk(ref_clk), .dout(dout_line), .strb(strb_line),
    .cs_n(cs_n), .sclk(sclk), .din(din));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    total_checks++;
    if (s !== x)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
    if (conv_start === 1'b1)
      nconv++;
  initial
  begin
    #1000000;
    fails++;
    stop_test;
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (8) @(negedge ref_clk);
    for (i = 0; i < 9; i++)
      i_host.sbit(1'b1, q);
    chk("deselected", nconv[7:0], 8'h00);
    $display("Test deselect done");
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      b = {1'b1, r[6:1], ~i[1]};
      if (i == 0)
        b = 8'hff;
      if (!b[3])
        b[2] = 1'b0;
      sar = r[15:8];
      below = r[16];
      e = (b[3] && !b[2] && below) ? 8'h00 : sar;
      i_host.frame(b, r[18:17], rx);
      chk("convs", nconv[7:0], 8'(i + 1));
      chk("strobe wait", {7'h00, i_host.late}, 8'h00);
      chk("lead", {6'h00, rx[15:14]}, 8'h00);
      chk("result", rx[13:6], e);
      if (b[0])
        chk("tail", {2'h0, rx[5:0]}, 8'h00);
      x = {4'h0, b[3], b[2], b[0], ~b[1]};
      chk("fields", flds, x);
      x = {5'h00, b[5], b[4], b[6]};
      chk("pos", {5'h00, chan_pos}, x);
      chk("common", {7'h00, neg_common}, {7'h00, b[2]});
      if (!b[2])
        chk("neg", {5'h00, chan_neg}, {5'h00, b[5], b[4], ~b[6]});
      x = {6'h00, b[5], b[6]};
      chk("pos4", {5'h00, pos4}, x);
      if (!b[2])
        chk("neg4", {5'h00, neg4}, {6'h00, b[5], ~b[6]});
      $display("Test %0d byte %h done", i, b);
    end
    stop_test;
  end
endmodule
`default_nettype wire
